// *** core/ioca_common_action.v ***
// Common action handler: decodes the shared opcodes, keeps the status flags,
// the communication watchdog, the identity data and the three indicators.
// Assumes commands arrive one per cycle from the gateway and the hardware
// watchdog and firmware restart logic sit outside and reset this block.
`timescale 1ns/1ps
`include "ioca_regs.vh"

// Overview of operation
// - Opcodes 0x00-0xEF go to module logic; 0xF0-0xFF are common actions.
// - Opcode 0xF0 restarts firmware at once, no response, no receive/transmit light.
// - During a reboot from either reset, commands are refused and nothing is sent.
// - Opcode 0xF1 stops watchdog servicing so a hardware reset follows; no response.
// - Opcode 0xF2 clears status bits under ones of the mask byte; no response.
// - The hard reset flag is not cleared by a client flag clear.
// - Every response packet starts with the status byte.
// - Opcode 0xF3 sets watchdog interval in 2 ms units; zero disables; no response.
// - Enabled watchdog expiring without gateway traffic forces a hardware reset.
// - Opcode 0xF5 returns the 16-bit model number, high byte first.
// - Opcode 0xF6 returns major then minor version, each 0 to 99.
// - Opcode 0xF7 returns the four-bit address shunt setting.
// - Opcode 0xFE answers presence, no payload, lights only link.
// - Receive lights on opcodes 0xF2, 0xF3, 0xF5-0xF7 and 0xFF, transmit on sent payload, link on those and 0xFE.
// - Opcode 0xFF changes nothing, returns status only, lights link and receive.
module ioca_common_action #(
	parameter TICK_CYCLES = `IOCA_TICK_CYCLES,
	parameter LED_CYCLES = `IOCA_LED_CYCLES,
	parameter [15:0] MODEL_NUMBER = `IOCA_MODEL_RESET // Arbitrary value
) (
	input wire i_sys_clk,
	input wire i_rstn,
	input wire i_ce,
	input wire [3:0] i_addr,
	input wire [31:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	output reg [31:0] o_rdata,
	input wire i_cmd_valid,
	input wire [7:0] i_cmd_opcode,
	input wire [7:0] i_cmd_arg,
	input wire i_cmd_from_client,
	output wire o_cmd_ready,
	output reg o_specific_valid,
	output reg [7:0] o_specific_opcode,
	output reg [7:0] o_specific_arg,
	input wire [7:0] i_status_set,
	input wire [3:0] i_address_shunt,
	output reg o_rsp_valid,
	output reg [7:0] o_rsp_byte,
	output reg o_rsp_last,
	output reg o_fw_restart,
	output wire o_wdt_service,
	output reg o_comm_wdt_expired,
	output wire o_link_indicator,
	output wire o_receive_indicator,
	output wire o_transmit_indicator
);
	localparam ST_RUN = 2'd0;
	localparam ST_SEND = 2'd1;
	localparam ST_REBOOT = 2'd2;

	// Payload bytes after the status byte for each common opcode
	function [1:0] payload_len;
		input [7:0] op;
		begin
			case (op)
				`IOCA_OP_MODEL_QUERY: payload_len = 2'd2;
				`IOCA_OP_VERSION_QUERY: payload_len = 2'd2;
				`IOCA_OP_ADDRESS_QUERY: payload_len = 2'd1;
				default: payload_len = 2'd0;
			endcase
		end
	endfunction

	// Opcodes that produce a response packet at all
	function has_packet;
		input [7:0] op;
		begin
			case (op)
				`IOCA_OP_MODEL_QUERY, `IOCA_OP_VERSION_QUERY, `IOCA_OP_ADDRESS_QUERY,
				`IOCA_OP_PRESENCE_PROBE, `IOCA_OP_NOP: has_packet = 1'b1;
				default: has_packet = 1'b0;
			endcase
		end
	endfunction

	reg rst_meta;
	reg rst_sync;
	reg [1:0] state;
	reg [7:0] status;
	reg [15:0] model_number_word;
	reg [7:0] major_version_byte;
	reg [7:0] minor_version_byte;
	reg [7:0] comm_interval;
	reg [7:0] ticks_left;
	reg [31:0] tick_count;
	reg wdt_stopped;
	reg [7:0] rsp_buf0;
	reg [7:0] rsp_buf1;
	reg [7:0] rsp_buf2;
	reg [1:0] rsp_idx;
	reg [1:0] rsp_end;
	reg rsp_payload;
	reg trig_link;
	reg trig_receive;
	reg trig_transmit;
	reg [7:0] next_status;
	reg [7:0] clear_mask_byte;

	wire accept;
	wire common;
	wire tick;

	always @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	// Ready drops while frozen so the gateway never sees a command taken that was not
	assign o_cmd_ready = (state == ST_RUN) && i_ce;
	assign accept = i_cmd_valid && o_cmd_ready;
	assign common = (i_cmd_opcode >= `IOCA_OP_COMMON_BASE);
	assign o_wdt_service = !wdt_stopped;
	assign tick = (tick_count == TICK_CYCLES - 1);

	// Status flags: hardware sets win over a clear in the same cycle
	always @* begin
		clear_mask_byte = 8'h00;
		if (accept && i_cmd_opcode == `IOCA_OP_FLAG_CLEAR) begin
			clear_mask_byte = i_cmd_arg;
			if (i_cmd_from_client)
				clear_mask_byte[`IOCA_HARD_RESET_FLAG_BIT] = 1'b0;
		end
		if (i_wr && i_addr == `IOCA_ADDR_STATUS)
			clear_mask_byte = clear_mask_byte | i_wdata[7:0];
		next_status = (status & ~clear_mask_byte) | i_status_set;
	end

	always @(posedge i_sys_clk or negedge rst_sync) begin
		if (!rst_sync) begin
			status <= `IOCA_STATUS_RESET;
			model_number_word <= MODEL_NUMBER;
			major_version_byte <= `IOCA_MAJOR_RESET;
			minor_version_byte <= `IOCA_MINOR_RESET;
			o_rdata <= 32'h00000000;
		end else if (i_ce) begin
			status <= next_status;
			if (i_wr && i_addr == `IOCA_ADDR_MODEL)
				model_number_word <= i_wdata[15:0];
			if (i_wr && i_addr == `IOCA_ADDR_VERSION) begin
				if (i_wdata[15:8] <= 8'h63)
					major_version_byte <= i_wdata[15:8];
				if (i_wdata[7:0] <= 8'h63)
					minor_version_byte <= i_wdata[7:0];
			end
			o_rdata <= 32'h00000000;
			if (i_rd) begin
				case (i_addr)
					`IOCA_ADDR_STATUS: o_rdata <= {24'h000000, status};
					`IOCA_ADDR_MODEL: o_rdata <= {16'h0000, model_number_word};
					`IOCA_ADDR_VERSION: o_rdata <= {16'h0000, major_version_byte, minor_version_byte};
					`IOCA_ADDR_COMM_WDT: o_rdata <= {14'h0000, wdt_stopped, (state == ST_REBOOT),
						ticks_left, comm_interval};
					default: o_rdata <= 32'h00000000;
				endcase
			end
		end
	end

	// Command decoder, response sequencer and communication watchdog
	always @(posedge i_sys_clk or negedge rst_sync) begin
		if (!rst_sync) begin
			state <= ST_RUN;
			comm_interval <= 8'h00;
			ticks_left <= 8'h00;
			tick_count <= 32'h00000000;
			wdt_stopped <= 1'b0;
			rsp_buf0 <= 8'h00;
			rsp_buf1 <= 8'h00;
			rsp_buf2 <= 8'h00;
			rsp_idx <= 2'd0;
			rsp_end <= 2'd0;
			rsp_payload <= 1'b0;
			o_rsp_valid <= 1'b0;
			o_rsp_byte <= 8'h00;
			o_rsp_last <= 1'b0;
			o_fw_restart <= 1'b0;
			o_comm_wdt_expired <= 1'b0;
			o_specific_valid <= 1'b0;
			o_specific_opcode <= 8'h00;
			o_specific_arg <= 8'h00;
			trig_link <= 1'b0;
			trig_receive <= 1'b0;
			trig_transmit <= 1'b0;
		end else if (i_ce) begin
			o_rsp_valid <= 1'b0;
			o_rsp_last <= 1'b0;
			o_fw_restart <= 1'b0;
			o_comm_wdt_expired <= 1'b0;
			o_specific_valid <= 1'b0;
			trig_link <= 1'b0;
			trig_receive <= 1'b0;
			trig_transmit <= 1'b0;

			// Watchdog counts 2 ms ticks while enabled and not rebooting
			if (comm_interval == 8'h00 || state == ST_REBOOT || accept) begin
				tick_count <= 32'h00000000;
			end else if (tick) begin
				tick_count <= 32'h00000000;
				if (ticks_left == 8'h01) begin
					state <= ST_REBOOT;
					wdt_stopped <= 1'b1;
					o_comm_wdt_expired <= 1'b1;
				end else begin
					ticks_left <= ticks_left - 8'h01;
				end
			end else begin
				tick_count <= tick_count + 32'h00000001;
			end
			if (accept)
				ticks_left <= comm_interval;

			case (state)
				ST_RUN: begin
					if (accept && !common) begin
						o_specific_valid <= 1'b1;
						o_specific_opcode <= i_cmd_opcode;
						o_specific_arg <= i_cmd_arg;
					end else if (accept) begin
						case (i_cmd_opcode)
							`IOCA_OP_FW_RESTART: begin
								o_fw_restart <= 1'b1;
								state <= ST_REBOOT;
							end
							`IOCA_OP_WDT_RESET: begin
								wdt_stopped <= 1'b1;
								state <= ST_REBOOT;
							end
							`IOCA_OP_FLAG_CLEAR: begin
								trig_link <= 1'b1;
								trig_receive <= 1'b1;
							end
							`IOCA_OP_COMM_TIMEOUT: begin
								comm_interval <= i_cmd_arg;
								ticks_left <= i_cmd_arg;
								trig_link <= 1'b1;
								trig_receive <= 1'b1;
							end
							`IOCA_OP_MODEL_QUERY, `IOCA_OP_VERSION_QUERY, `IOCA_OP_ADDRESS_QUERY,
							`IOCA_OP_NOP: begin
								trig_link <= 1'b1;
								trig_receive <= 1'b1;
							end
							`IOCA_OP_PRESENCE_PROBE: begin
								trig_link <= 1'b1;
							end
							default: begin
							end
						endcase
						if (has_packet(i_cmd_opcode)) begin
							state <= ST_SEND;
							rsp_idx <= 2'd0;
							rsp_end <= payload_len(i_cmd_opcode);
							rsp_payload <= (payload_len(i_cmd_opcode) != 2'd0);
							rsp_buf0 <= next_status;
							case (i_cmd_opcode)
								`IOCA_OP_MODEL_QUERY: begin
									rsp_buf1 <= model_number_word[15:8];
									rsp_buf2 <= model_number_word[7:0];
								end
								`IOCA_OP_VERSION_QUERY: begin
									rsp_buf1 <= major_version_byte;
									rsp_buf2 <= minor_version_byte;
								end
								default: begin
									rsp_buf1 <= {4'h0, i_address_shunt} & `IOCA_ADDRESS_MASK;
									rsp_buf2 <= 8'h00;
								end
							endcase
						end
					end
				end
				ST_SEND: begin
					o_rsp_valid <= 1'b1;
					o_rsp_byte <= (rsp_idx == 2'd0) ? rsp_buf0 : (rsp_idx == 2'd1) ? rsp_buf1 : rsp_buf2;
					rsp_idx <= rsp_idx + 2'd1;
					if (rsp_idx == rsp_end) begin
						o_rsp_last <= 1'b1;
						trig_transmit <= rsp_payload;
						state <= ST_RUN;
					end
				end
				ST_REBOOT: begin
					// Held until the outside restart or watchdog resets the block
				end
				default: begin
					state <= ST_RUN;
				end
			endcase
		end
	end

	ioca_led_stretch #(.CYCLES(LED_CYCLES)) u_link (
		.i_sys_clk(i_sys_clk),
		.i_rstn(rst_sync),
		.i_ce(i_ce),
		.i_trig(trig_link),
		.o_led(o_link_indicator)
	);

	ioca_led_stretch #(.CYCLES(LED_CYCLES)) u_receive (
		.i_sys_clk(i_sys_clk),
		.i_rstn(rst_sync),
		.i_ce(i_ce),
		.i_trig(trig_receive),
		.o_led(o_receive_indicator)
	);

	ioca_led_stretch #(.CYCLES(LED_CYCLES)) u_transmit (
		.i_sys_clk(i_sys_clk),
		.i_rstn(rst_sync),
		.i_ce(i_ce),
		.i_trig(trig_transmit),
		.o_led(o_transmit_indicator)
	);
endmodule // ioca_common_action

// *** core/ioca_regs.vh ***
// Constants for the common action handler of a field I/O module.
// Assumes a 125 MHz module clock; included by bare name.
`ifndef IOCA_REGS_VH
`define IOCA_REGS_VH

// Opcode ranges and common opcodes
`define IOCA_OP_COMMON_BASE 8'hf0
`define IOCA_OP_FW_RESTART 8'hf0
`define IOCA_OP_WDT_RESET 8'hf1
`define IOCA_OP_FLAG_CLEAR 8'hf2
`define IOCA_OP_COMM_TIMEOUT 8'hf3
`define IOCA_OP_MODEL_QUERY 8'hf5
`define IOCA_OP_VERSION_QUERY 8'hf6
`define IOCA_OP_ADDRESS_QUERY 8'hf7
`define IOCA_OP_PRESENCE_PROBE 8'hfe
`define IOCA_OP_NOP 8'hff

// Register byte addresses
`define IOCA_ADDR_STATUS 4'h0
`define IOCA_ADDR_MODEL 4'h4
`define IOCA_ADDR_VERSION 4'h8
`define IOCA_ADDR_COMM_WDT 4'hc

// Status byte fields and reset values
`define IOCA_HARD_RESET_FLAG_BIT 7
`define IOCA_STATUS_RESET 8'h80
`define IOCA_MODEL_RESET 16'h0001
`define IOCA_MAJOR_RESET 8'h01
`define IOCA_MINOR_RESET 8'h00
`define IOCA_ADDRESS_MASK 8'h0f

// Timing
`define IOCA_CLK_KHZ 125000
`define IOCA_TICK_MS 2
`define IOCA_TICK_CYCLES (`IOCA_TICK_MS * `IOCA_CLK_KHZ)
`define IOCA_LED_MS 100
`define IOCA_LED_CYCLES (`IOCA_LED_MS * `IOCA_CLK_KHZ)

`endif

// *** core/ioca_led_stretch.v ***
// Indicator pulse stretcher: a one-cycle trigger lights the output for a fixed time.
// Assumes an asynchronous active-low reset and a clock enable from the parent.
`timescale 1ns/1ps
module ioca_led_stretch #(
	parameter CYCLES = 12500000
) (
	input wire i_sys_clk,
	input wire i_rstn,
	input wire i_ce,
	input wire i_trig,
	output reg o_led
);
	reg [23:0] count;

	always @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			count <= 24'h000000;
			o_led <= 1'b0;
		end else if (i_ce) begin
			if (i_trig) begin
				count <= CYCLES[23:0] - 24'h000001;
				o_led <= 1'b1;
			end else if (count != 24'h000000) begin
				count <= count - 24'h000001;
			end else begin
				o_led <= 1'b0;
			end
		end
	end
endmodule // ioca_led_stretch

// *** verif/ioca_common_action_sva.sv ***
// Port checker for the common action handler.
// Assumes i_ce is held high while commands are presented.
`timescale 1ns/1ps
module ioca_common_action_sva (
	input wire i_sys_clk,
	input wire i_rstn,
	input wire i_ce,
	input wire i_cmd_valid,
	input wire [7:0] i_cmd_opcode,
	input wire [7:0] i_cmd_arg,
	input wire [3:0] i_address_shunt,
	input wire o_cmd_ready,
	input wire o_specific_valid,
	input wire [7:0] o_specific_opcode,
	input wire [7:0] o_specific_arg,
	input wire o_rsp_valid,
	input wire [7:0] o_rsp_byte,
	input wire o_rsp_last,
	input wire o_fw_restart,
	input wire o_wdt_service,
	input wire o_comm_wdt_expired,
	input wire o_link_indicator,
	input wire o_receive_indicator,
	input wire o_transmit_indicator
);
	wire tk = i_cmd_valid && o_cmd_ready && i_ce;
	wire [7:0] op = i_cmd_opcode;
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rstn);
	split_fwd_a: assert property (tk && op < 8'hf0 |=> o_specific_valid && o_specific_opcode == $past(op)
		&& o_specific_arg == $past(i_cmd_arg))
		else $error("module opcode not forwarded");
	restart_pulse_a: assert property (tk && op == 8'hf0 |=> o_fw_restart)
		else $error("no restart pulse");
	reboot_quiet_a: assert property (o_fw_restart || !o_wdt_service |-> !o_cmd_ready && !o_rsp_valid)
		else $error("active during reboot");
	wdt_stop_a: assert property (tk && op == 8'hf1 |=> !o_wdt_service)
		else $error("watchdog still serviced");
	model_len_a: assert property (tk && op == 8'hf5 |=> ##1 o_rsp_valid && !o_rsp_last ##1 o_rsp_valid && !o_rsp_last
		##1 o_rsp_valid && o_rsp_last)
		else $error("model packet length wrong");
	addr_byte_a: assert property (tk && op == 8'hf7 |=> ##2 o_rsp_last && o_rsp_byte == {4'h0, i_address_shunt})
		else $error("address byte wrong");
	status_only_a: assert property (tk && (op == 8'hfe || op == 8'hff) |=> ##1 o_rsp_last && o_link_indicator)
		else $error("status packet wrong");
	rx_led_a: assert property (tk && (op == 8'hf5 || op == 8'hff) |=> ##1 o_receive_indicator)
		else $error("receive indicator dark");
	tx_led_a: assert property (tk && op == 8'hf6 |=> ##4 o_transmit_indicator)
		else $error("transmit indicator dark");
	quiet_led_a: assert property (tk && (op == 8'hf0 || op == 8'hfe) |=> ##1 !o_receive_indicator
		&& !o_transmit_indicator)
		else $error("receive or transmit lit");
	reserved_quiet_a: assert property (tk && (op == 8'hf4 || (op > 8'hf7 && op < 8'hfe)) |=> !o_rsp_valid [*3])
		else $error("reserved opcode answered");
	expire_stop_a: assert property (o_comm_wdt_expired |-> ##[0:2] !o_wdt_service)
		else $error("expiry left watchdog serviced");
endmodule // ioca_common_action_sva

bind ioca_common_action ioca_common_action_sva chk (.i_sys_clk, .i_rstn, .i_ce, .i_cmd_valid, .i_cmd_opcode,
	.i_cmd_arg, .i_address_shunt, .o_cmd_ready, .o_specific_valid, .o_specific_opcode, .o_specific_arg,
	.o_rsp_valid, .o_rsp_byte, .o_rsp_last,
	.o_fw_restart, .o_wdt_service, .o_comm_wdt_expired, .o_link_indicator, .o_receive_indicator, .o_transmit_indicator);

// *** verif/ioca_gateway_model.sv ***
// Gateway model: presents one command and gathers the reply bytes.
// Assumes one caller at a time.
`timescale 1ns/1ps
module ioca_gateway_model (
	input wire i_sys_clk,
	input wire i_cmd_ready,
	input wire i_rsp_valid,
	input wire [7:0] i_rsp_byte,
	output reg o_cmd_valid = 1'b0,
	output reg [7:0] o_cmd_opcode = 8'h00,
	output reg [7:0] o_cmd_arg = 8'h00,
	output reg o_cmd_from_client = 1'b0
);
	reg [7:0] rb [0:3];
	integer nb;
	// Refused for 20 cycles means dropped
	task send(input [7:0] op, input [7:0] arg, input cl, output ok);
		integer n;
		begin
			ok = 1'b0;
			nb = 0;
			@(posedge i_sys_clk);
			o_cmd_valid <= 1'b1;
			o_cmd_opcode <= op;
			o_cmd_arg <= arg;
			o_cmd_from_client <= cl;
			for (n = 0; n < 20 && !ok; n = n + 1) begin
				@(posedge i_sys_clk);
				ok = i_cmd_ready;
			end
			o_cmd_valid <= 1'b0;
			o_cmd_opcode <= ~op;
			o_cmd_arg <= ~arg;
			repeat (5) begin
				@(posedge i_sys_clk);
				if (i_rsp_valid && nb < 4) begin
					rb[nb] = i_rsp_byte;
					nb = nb + 1;
				end
			end
		end
	endtask
endmodule // ioca_gateway_model

// *** verif/ioca_common_action_bench.sv ***
// Bench: table of queries, then registers, flags, watchdog and resets.
// Assumes the gateway model drives the command port.
`timescale 1ns/1ps
`define CHK(a, b) begin checks = checks + 1; if ((a) !== (b)) begin errors = errors + 1; \
	$display("[ERR] %0t got %h want %h", $time, a, b); end end
module ioca_common_action_bench;
	reg i_sys_clk = 1'b0, i_rstn = 1'b0, i_ce = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
	reg [3:0] i_addr = 4'h0, i_address_shunt = 4'ha;
	reg [31:0] i_wdata = 32'h0;
	reg [7:0] i_status_set = 8'h00;
	wire [31:0] o_rdata;
	wire i_cmd_valid, i_cmd_from_client, o_cmd_ready, o_specific_valid, o_rsp_valid, o_rsp_last, o_fw_restart;
	wire o_wdt_service, o_comm_wdt_expired, o_link_indicator, o_receive_indicator, o_transmit_indicator;
	wire [7:0] i_cmd_opcode, i_cmd_arg, o_specific_opcode, o_specific_arg, o_rsp_byte;
	integer errors = 0, checks = 0, i, n;
	reg ok;
	reg [31:0] d;
	reg [39:0] rows [0:5] = '{40'hf5_03_80_5a_3c, 40'hf6_03_80_01_00, 40'hf7_02_80_0a_00, 40'hfe_01_80_00_00,
		40'hff_01_80_00_00, 40'h12_00_00_00_00};
	always #4 i_sys_clk = ~i_sys_clk;
	ioca_common_action #(.TICK_CYCLES(10), .LED_CYCLES(4), .MODEL_NUMBER(16'h5a3c)) dut (.i_sys_clk, .i_rstn, .i_ce,
		.i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_cmd_valid, .i_cmd_opcode, .i_cmd_arg, .i_cmd_from_client,
		.o_cmd_ready, .o_specific_valid, .o_specific_opcode, .o_specific_arg, .i_status_set, .i_address_shunt,
		.o_rsp_valid, .o_rsp_byte, .o_rsp_last, .o_fw_restart, .o_wdt_service, .o_comm_wdt_expired,
		.o_link_indicator, .o_receive_indicator, .o_transmit_indicator);
	ioca_gateway_model gw (.i_sys_clk, .i_cmd_ready(o_cmd_ready), .i_rsp_valid(o_rsp_valid), .i_rsp_byte(o_rsp_byte),
		.o_cmd_valid(i_cmd_valid), .o_cmd_opcode(i_cmd_opcode), .o_cmd_arg(i_cmd_arg),
		.o_cmd_from_client(i_cmd_from_client));
	task report_and_stop;
		begin
			$display("checks %0d errors %0d", checks, errors);
			if (errors == 0 && checks > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask
	task go(input [7:0] op, input [7:0] arg, input cl);
		begin
			gw.send(op, arg, cl, ok);
			`CHK(ok, 1'b1)
			if (!ok)
				report_and_stop;
		end
	endtask
	task rst;
		begin
			i_rstn <= 1'b0;
			repeat (12) @(posedge i_sys_clk);
			i_rstn <= 1'b1;
			repeat (3) @(posedge i_sys_clk);
		end
	endtask
	task bus(input w, input [3:0] a, input [31:0] v);
		begin
			@(posedge i_sys_clk);
			i_wr <= w;
			i_rd <= !w;
			i_addr <= a;
			i_wdata <= v;
			@(posedge i_sys_clk);
			i_wr <= 1'b0;
			i_rd <= 1'b0;
			@(posedge i_sys_clk);
			d = o_rdata;
		end
	endtask
	initial begin
		rst;
		go(8'hf3, 8'h00, 1'b0);
		n = 0;
		repeat (60) @(posedge i_sys_clk) n = n + o_comm_wdt_expired;
		`CHK(n, 0);
		for (i = 0; i < 6; i = i + 1) begin
			go(rows[i][39:32], 8'h34, 1'b0);
			`CHK(gw.nb, rows[i][31:24]);
			for (n = 0; n < gw.nb && n < 3; n = n + 1)
				`CHK(gw.rb[n], rows[i][23 - 8 * n -: 8]);
		end
		for (n = 8'hf4; n < 8'hfe; n = n + 1)
			if (n < 8'hf5 || n > 8'hf7) begin
				go(n[7:0], 8'h00, 1'b0);
				`CHK(gw.nb, 0);
			end
		$display("table done");
		bus(1'b0, 4'h4, 32'h0);
		`CHK(d[15:0], 16'h5a3c);
		bus(1'b1, 4'h8, 32'h0964);
		go(8'hf6, 8'h00, 1'b0);
		`CHK({gw.rb[1], gw.rb[2]}, 16'h0900);
		bus(1'b1, 4'h2, 32'hffff);
		bus(1'b0, 4'h2, 32'h0);
		`CHK(d, 32'h0);
		$display("registers done");
		@(posedge i_sys_clk) i_status_set <= 8'h0f;
		@(posedge i_sys_clk) i_status_set <= 8'h00;
		go(8'hf2, 8'h85, 1'b1);
		`CHK(gw.nb, 0);
		go(8'hff, 8'h00, 1'b0);
		`CHK(gw.rb[0], 8'h8a);
		go(8'hf2, 8'h80, 1'b0);
		go(8'hff, 8'h00, 1'b0);
		`CHK(gw.rb[0], 8'h0a);
		$display("flags done");
		go(8'hf3, 8'h02, 1'b0);
		for (n = 0; n < 40 && !o_comm_wdt_expired; n = n + 1) @(posedge i_sys_clk);
		`CHK(n >= 12 && n <= 18, 1'b1);
		if (n == 40)
			report_and_stop;
		repeat (3) @(posedge i_sys_clk);
		`CHK(o_wdt_service, 1'b0);
		gw.send(8'hff, 8'h00, 1'b0, ok);
		`CHK(ok, 1'b0);
		$display("watchdog done");
		rst;
		go(8'hff, 8'h00, 1'b0);
		`CHK(gw.rb[0], 8'h80);
		go(8'hf1, 8'h00, 1'b0);
		`CHK(gw.nb, 0);
		`CHK(o_wdt_service, 1'b0);
		gw.send(8'hff, 8'h00, 1'b0, ok);
		`CHK(ok, 1'b0);
		rst;
		go(8'hf0, 8'h00, 1'b0);
		`CHK(gw.nb, 0);
		`CHK(o_cmd_ready, 1'b0);
		$display("resets done");
		report_and_stop;
	end
endmodule // ioca_common_action_bench
